// ==== design/clock_pulse_generator.sv ====
/*
  Clock pulse generator control with settling watchdog counter.
  Clock outputs are one-cycle enables on hclk, which stands for the
  first PLL output. Assumes an AHB-Lite master and synchronous pins.
*/
`timescale 1ns/10ps
module clock_pulse_generator #(
  parameter int MODULES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mode_select_bit0,
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  input wire logic external_clock_input,
  output logic crystal_drive_output,
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe,
  input wire logic sleep_req,
  input wire logic wake_req,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic bus_clk_en,
  output logic [MODULES-1:0] module_clk_en,
  output logic crystal_osc_on,
  output logic pll2_on,
  output logic [2:0] pll2_ratio,
  output logic [2:0] pll1_ratio,
  output logic mode_reserved,
  output logic power_on_reset_req,
  output logic manual_reset_req,
  output logic timer_irq
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_STANDBY = 4'h4,
    ST_SETTLE = 4'h8
  } pm_state_t;
  pm_state_t state_r; // Power state
  logic [15:0] freq_r; // Frequency control register
  logic [7:0] wd_count_r; // Watchdog up counter
  logic [7:0] wd_ctrl_r; // Watchdog control
  logic [15:0] stby_r; // Standby control
  logic [2:0] mode_r; // Mode pins caught after reset
  logic mode_taken_r; // Mode pins already caught
  logic [2:0] mult; // First PLL ratio
  logic [2:0] core_div; // Core divide, clamped
  logic [2:0] per_div; // Peripheral divide, clamped
  logic [2:0] bus_cnt_r;
  logic [2:0] core_cnt_r;
  logic [2:0] per_cnt_r;
  logic bus_in_r; // Previous bus pin level
  logic bus_tick; // Bus clock rising point
  logic per_tick; // Internal peripheral tick
  logic [11:0] pre_r; // Watchdog prescaler
  logic wd_tick; // Watchdog count enable
  logic wd_run; // Counter is counting
  logic wd_ovf; // Counter wraps this cycle
  logic run_clk; // Base clock not stopped
  logic ap_wr_r; // Pending write data phase
  logic [31:0] ap_addr_r; // Pending address
  logic ap_valid; // Address phase taken
  logic wr_freq;
  logic wr_cnt;
  logic wr_ctl;
  logic wr_stby;
  logic mult_change; // Write alters first PLL ratio

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  // Pins are caught once, on the first enabled edge after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= 3'h0;
      mode_taken_r <= 1'b0;
    end
    else if (clk_en && !mode_taken_r)
    begin
      mode_r <= {mode_select_bit2, mode_select_bit1, mode_select_bit0};
      mode_taken_r <= 1'b1;
    end
  end

  // Second PLL and oscillator follow the mode only
  always_comb
  begin
    mode_reserved = !(mode_r == clk_gen_pkg::MODE_EXT_X1 ||
      mode_r == clk_gen_pkg::MODE_EXT_X4 ||
      mode_r == clk_gen_pkg::MODE_CRYSTAL_DRIVE_OUTPUT_X4 ||
      mode_r == clk_gen_pkg::MODE_BUS_IN);
    pll2_on = mode_r != clk_gen_pkg::MODE_BUS_IN;
    pll2_ratio = (mode_r == clk_gen_pkg::MODE_EXT_X4 ||
      mode_r == clk_gen_pkg::MODE_CRYSTAL_DRIVE_OUTPUT_X4) ?
      clk_gen_pkg::PLL2_RATIO_HIGH : clk_gen_pkg::PLL2_RATIO_LOW;
    crystal_osc_on = mode_r == clk_gen_pkg::MODE_CRYSTAL_DRIVE_OUTPUT_X4;
  end

  // Crystal drive inverts the input while the oscillator runs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      crystal_drive_output <= 1'b0;
    else if (clk_en)
      crystal_drive_output <= crystal_osc_on & ~external_clock_input;
  end

  // ------------------------------------------------------------------
  // Ratio decode with limits
  // ------------------------------------------------------------------
  // Core never slower than bus, peripheral never faster
  always_comb
  begin
    mult = clk_gen_pkg::ratio({freq_r[clk_gen_pkg::MULT_HI_BIT],
      freq_r[clk_gen_pkg::MULT_LO +: 2]});
    core_div = clk_gen_pkg::ratio({freq_r[clk_gen_pkg::CORE_HI_BIT],
      freq_r[clk_gen_pkg::CORE_LO +: 2]});
    per_div = clk_gen_pkg::ratio({freq_r[clk_gen_pkg::PER_HI_BIT],
      freq_r[clk_gen_pkg::PER_LO +: 2]});
    if (core_div > mult)
      core_div = mult;
    if (per_div < mult)
      per_div = mult;
    pll1_ratio = mult;
  end

  // ------------------------------------------------------------------
  // Dividers
  // ------------------------------------------------------------------
  assign run_clk = clk_en && state_r != ST_STANDBY;
  assign bus_tick = (mode_r == clk_gen_pkg::MODE_BUS_IN) ?
    (bus_clock_pin_i && !bus_in_r) : (bus_cnt_r == 3'h0);
  assign per_tick = per_cnt_r == 3'h0;

  // Bus divider, or edge detect of the bus pin in mode 7
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_cnt_r <= 3'h0;
      bus_in_r <= 1'b1; // Reads high so reset never fakes an edge
      bus_clock_pin_o <= 1'b0;
    end
    else if (run_clk)
    begin
      // Held until the mode is caught so the first sample is real
      if (mode_taken_r)
        bus_in_r <= bus_clock_pin_i;
      if (bus_cnt_r >= mult - 3'h1)
        bus_cnt_r <= 3'h0;
      else
        bus_cnt_r <= bus_cnt_r + 3'h1;
      // High for the first half of each bus period
      bus_clock_pin_o <= (bus_cnt_r >= mult - 3'h1) ||
        ({bus_cnt_r, 1'b0} + 4'h2 < {1'b0, mult});
    end
  end

  // Pin drives only outside mode 7 and when enabled by software
  assign bus_clock_pin_oe = mode_r != clk_gen_pkg::MODE_BUS_IN &&
    freq_r[clk_gen_pkg::BUS_OE_BIT];

  // Core divider restarts on each bus edge; peripheral divider runs free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_cnt_r <= 3'h0;
      per_cnt_r <= 3'h0;
    end
    else if (run_clk)
    begin
      if (bus_tick || core_cnt_r >= core_div - 3'h1)
        core_cnt_r <= (bus_tick && core_div > 3'h1) ? 3'h1 : 3'h0;
      else
        core_cnt_r <= core_cnt_r + 3'h1;
      if (per_cnt_r >= per_div - 3'h1)
        per_cnt_r <= 3'h0;
      else
        per_cnt_r <= per_cnt_r + 3'h1;
    end
  end

  // Gated clock enables per power state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      bus_clk_en <= 1'b0;
    end
    else if (clk_en)
    begin
      core_clk_en <= state_r == ST_RUN && (bus_tick || core_cnt_r == 3'h0);
      periph_clk_en <= per_tick &&
        (state_r == ST_RUN || state_r == ST_SLEEP);
      bus_clk_en <= bus_tick && run_clk && state_r != ST_SETTLE;
    end
  end

  // Module stop bits gate the peripheral clock per module
  for (genvar g = 0; g < MODULES; g++)
  begin : g_mstop
    assign module_clk_en[g] = periph_clk_en &&
      !stby_r[clk_gen_pkg::MSTOP_LO + g];
  end

  // ------------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------------
  // A ratio change in run, or wake from standby, passes through settling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_RUN;
    else if (clk_en)
    begin
      unique case (state_r)
        ST_RUN:
          if (mult_change)
            state_r <= ST_SETTLE;
          else if (sleep_req)
            state_r <= stby_r[clk_gen_pkg::STBY_SEL_BIT] ?
              ST_STANDBY : ST_SLEEP;
        ST_SLEEP:
          if (wake_req)
            state_r <= ST_RUN;
        ST_STANDBY:
          if (wake_req)
            state_r <= ST_SETTLE;
        ST_SETTLE:
          if (wd_ovf)
            state_r <= ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------------
  // Prescaler taps: 1, 4, 16, 32, 64, 256, 1024, 4096
  always_comb
  begin
    unique case (wd_ctrl_r[2:0])
      3'h0: wd_tick = 1'b1;
      3'h1: wd_tick = &pre_r[1:0];
      3'h2: wd_tick = &pre_r[3:0];
      3'h3: wd_tick = &pre_r[4:0];
      3'h4: wd_tick = &pre_r[5:0];
      3'h5: wd_tick = &pre_r[7:0];
      3'h6: wd_tick = &pre_r[9:0];
      3'h7: wd_tick = &pre_r[11:0];
    endcase
    wd_run = run_clk && per_tick &&
      (wd_ctrl_r[clk_gen_pkg::WD_EN_BIT] || state_r == ST_SETTLE);
    wd_ovf = wd_run && wd_tick && wd_count_r == 8'hff;
  end

  // Prescaler and counter advance on the peripheral tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_r <= 12'h000;
      wd_count_r <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wd_run)
        pre_r <= pre_r + 12'h001;
      if (wr_cnt)
        wd_count_r <= hwdata[7:0];
      else if (wd_run && wd_tick)
        wd_count_r <= wd_count_r + 8'h01;
    end
  end

  // Overflow outcome per timer mode; settling overflow is silent
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power_on_reset_req <= 1'b0;
      manual_reset_req <= 1'b0;
    end
    else if (clk_en)
    begin
      power_on_reset_req <= wd_ovf && state_r != ST_SETTLE &&
        wd_ctrl_r[clk_gen_pkg::WD_MODE_BIT] &&
        !wd_ctrl_r[clk_gen_pkg::WD_RSEL_BIT];
      manual_reset_req <= wd_ovf && state_r != ST_SETTLE &&
        wd_ctrl_r[clk_gen_pkg::WD_MODE_BIT] &&
        wd_ctrl_r[clk_gen_pkg::WD_RSEL_BIT];
    end
  end

  // Interrupt follows the overflow flag in interval mode
  assign timer_irq = wd_ctrl_r[clk_gen_pkg::WD_OVF_BIT] &&
    !wd_ctrl_r[clk_gen_pkg::WD_MODE_BIT];

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_freq = ap_wr_r && ap_addr_r == clk_gen_pkg::FREQ_CTRL_ADDR;
  assign wr_cnt = ap_wr_r && ap_addr_r == clk_gen_pkg::WD_COUNT_ADDR;
  assign wr_ctl = ap_wr_r && ap_addr_r == clk_gen_pkg::WD_CTRL_ADDR;
  assign wr_stby = ap_wr_r && ap_addr_r == clk_gen_pkg::STBY_CTRL_ADDR;
  assign mult_change = wr_freq &&
    ({hwdata[clk_gen_pkg::MULT_HI_BIT], hwdata[clk_gen_pkg::MULT_LO +: 2]}
    != {freq_r[clk_gen_pkg::MULT_HI_BIT], freq_r[clk_gen_pkg::MULT_LO +: 2]});

  // Address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      ap_wr_r <= ap_valid && hwrite;
      ap_addr_r <= haddr;
      if (ap_valid && !hwrite)
      begin
        unique case (haddr)
          clk_gen_pkg::FREQ_CTRL_ADDR: hrdata <= {16'h0000, freq_r};
          clk_gen_pkg::WD_COUNT_ADDR: hrdata <= {24'h000000, wd_count_r};
          clk_gen_pkg::WD_CTRL_ADDR: hrdata <= {24'h000000, wd_ctrl_r};
          clk_gen_pkg::STBY_CTRL_ADDR: hrdata <= {16'h0000, stby_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes; overflow flag set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_r <= clk_gen_pkg::FREQ_CTRL_RESET;
      wd_ctrl_r <= clk_gen_pkg::WD_CTRL_RESET;
      stby_r <= clk_gen_pkg::STBY_CTRL_RESET;
    end
    else if (clk_en)
    begin
      if (wr_freq)
        freq_r <= hwdata[15:0];
      if (wr_stby)
        stby_r <= hwdata[15:0];
      if (wr_ctl)
        wd_ctrl_r <= hwdata[7:0];
      if (wd_ovf && state_r != ST_SETTLE)
        wd_ctrl_r[clk_gen_pkg::WD_OVF_BIT] <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_wake;
    state_r == ST_STANDBY && wake_req && clk_en;
  endsequence
  sequence s_settled;
    state_r == ST_SETTLE;
  endsequence

  // Every bus pulse in run carries a core pulse with it
  a_core_limit: assert property (@(posedge hclk)
    disable iff (!hresetn) bus_clk_en && $past(state_r) == ST_RUN
    |-> core_clk_en) else $error("core slower than bus");
  a_per_limit: assert property (@(posedge hclk)
    disable iff (!hresetn) per_div >= mult)
    else $error("periph faster than bus");
  a_wake_settle: assert property (@(posedge hclk)
    disable iff (!hresetn) s_wake |=> s_settled)
    else $error("no settling on wake");
  a_change_settle: assert property (@(posedge hclk)
    disable iff (!hresetn)
    clk_en && state_r == ST_RUN && mult_change |=> state_r == ST_SETTLE)
    else $error("ratio change not settled");
  a_settle_core_off: assert property (@(posedge hclk)
    disable iff (!hresetn) $past(state_r) == ST_SETTLE |-> !core_clk_en)
    else $error("core ran while settling");
  a_wd_reset: assert property (@(posedge hclk)
    disable iff (!hresetn) clk_en && wd_ovf && state_r == ST_RUN &&
    wd_ctrl_r[clk_gen_pkg::WD_MODE_BIT] |=>
    power_on_reset_req || manual_reset_req)
    else $error("overflow gave no reset");
  a_irq_set: assert property (@(posedge hclk)
    disable iff (!hresetn) clk_en && wd_ovf && state_r == ST_RUN &&
    !wd_ctrl_r[clk_gen_pkg::WD_MODE_BIT] |=> timer_irq)
    else $error("overflow gave no interrupt");
  a_pll2_ratio: assert property (@(posedge hclk)
    disable iff (!hresetn)
    mode_r == clk_gen_pkg::MODE_EXT_X1 |-> pll2_ratio == 3'h1 && pll2_on)
    else $error("mode 0 ratio wrong");
  a_mode7_pin: assert property (@(posedge hclk)
    disable iff (!hresetn)
    mode_r == clk_gen_pkg::MODE_BUS_IN |-> !bus_clock_pin_oe && !pll2_on)
    else $error("bus pin driven in mode 7");
endmodule // clock_pulse_generator

// ==== design/clk_gen_pkg.sv ====
/*
  Constants for the clock pulse generator control block: register map,
  field positions, reset values, clock mode codes and ratio decoding.
  Assumes a 32-bit AHB-Lite register bus and one 20 MHz system clock.
*/
package clk_gen_pkg;
  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [31:0] FREQ_CTRL_ADDR = 32'hffff_ff80;
  localparam logic [31:0] WD_COUNT_ADDR = 32'hffff_ff84;
  localparam logic [31:0] WD_CTRL_ADDR = 32'hffff_ff88;
  localparam logic [31:0] STBY_CTRL_ADDR = 32'hffff_ff8c;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] FREQ_CTRL_RESET = 16'h0102;
  localparam logic [7:0] WD_CTRL_RESET = 8'h00;
  localparam logic [15:0] STBY_CTRL_RESET = 16'h0000;
  // ------------------------------------------------------------------
  // Frequency control fields: 3-bit codes {hi bit, lo pair}
  // ------------------------------------------------------------------
  localparam int MULT_HI_BIT = 15;
  localparam int CORE_HI_BIT = 14;
  localparam int PER_HI_BIT = 13;
  localparam int BUS_OE_BIT = 8;
  localparam int MULT_LO = 4;
  localparam int CORE_LO = 2;
  localparam int PER_LO = 0;
  // ------------------------------------------------------------------
  // Watchdog control and standby control fields
  // ------------------------------------------------------------------
  localparam int WD_EN_BIT = 7;
  localparam int WD_MODE_BIT = 6;
  localparam int WD_RSEL_BIT = 5;
  localparam int WD_OVF_BIT = 3;
  localparam int STBY_SEL_BIT = 0;
  localparam int MSTOP_LO = 8;
  // ------------------------------------------------------------------
  // Clock operating modes on the mode-select pins
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_EXT_X1 = 3'h0;
  localparam logic [2:0] MODE_EXT_X4 = 3'h1;
  localparam logic [2:0] MODE_CRYSTAL_DRIVE_OUTPUT_X4 = 3'h2;
  localparam logic [2:0] MODE_BUS_IN = 3'h7;
  localparam logic [2:0] PLL2_RATIO_LOW = 3'h1;
  localparam logic [2:0] PLL2_RATIO_HIGH = 3'h4;
  // Ratio code: 000 x1, 001 x2, 010 x4, 100 x3, 101 x6, else x1
  function automatic logic [2:0] ratio(input logic [2:0] code);
    unique case (code)
      3'h1: ratio = 3'h2;
      3'h2: ratio = 3'h4;
      3'h4: ratio = 3'h3;
      3'h5: ratio = 3'h6;
      default: ratio = 3'h1;
    endcase
  endfunction
endpackage

// ==== dv/clock_source_model.sv ====
/*
  Far-side model: free-running external clock source and the far
  device on the two-way bus clock pin.
  Assumes the pin is resolved here from the design's enable.
*/
`timescale 1ns/10ps
module clock_source_model #(
  parameter int EXT_HALF = 25,
  parameter int PIN_HALF = 200
) (
  output logic ext_clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_level
);
  logic pin_clk; // Far-side clock offered on the bus pin
  // -----------------------------------------------------------------
  // Oscillators run free, at fixed phase offsets from hclk
  // -----------------------------------------------------------------
  initial
  begin
    ext_clk = 1'b0;
    #7; // Edges kept off hclk edges; low at every rising edge
    forever #(EXT_HALF) ext_clk = ~ext_clk;
  end
  initial
  begin
    pin_clk = 1'b0;
    #37;
    forever #(PIN_HALF) pin_clk = ~pin_clk;
  end
  // Wire level: design drives when enabled, else far side drives
  assign pin_level = pin_oe ? pin_o : pin_clk;
endmodule // clock_source_model

// ==== dv/testbench.sv ====
/*
  Self-checking bench for the clock pulse generator control block.
  Assumes one 20 MHz hclk and an AHB-Lite master driven here.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  logic hclk, hresetn, hsel, hwrite, sleep_req, wake_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, md, pll2_ratio, pll1_ratio;
  logic hreadyout, crystal_osc_on, pll2_on, mode_reserved, ext, pin_i;
  logic pin_o, pin_oe, core_en, per_en, bus_en, por_req, man_req, irq;
  logic clk_en, hresp, xdrv;
  logic [7:0] mod_en;
  int mismatches = 0;
  int checked = 0;
  int n;
  clock_pulse_generator DUT (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_select_bit0(md[0]), .mode_select_bit1(md[1]),
    .mode_select_bit2(md[2]), .external_clock_input(ext),
    .crystal_drive_output(xdrv), .bus_clock_pin_i(pin_i),
    .bus_clock_pin_o(pin_o), .bus_clock_pin_oe(pin_oe),
    .sleep_req(sleep_req), .wake_req(wake_req), .core_clk_en(core_en),
    .periph_clk_en(per_en), .bus_clk_en(bus_en), .module_clk_en(mod_en),
    .crystal_osc_on(crystal_osc_on), .pll2_on(pll2_on),
    .pll2_ratio(pll2_ratio), .pll1_ratio(pll1_ratio),
    .mode_reserved(mode_reserved), .power_on_reset_req(por_req),
    .manual_reset_req(man_req), .timer_irq(irq));
  clock_source_model src (.ext_clk(ext), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_level(pin_i));
  // -----------------------------------------------------------------
  // Clock, watchdog and closing
  // -----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    #4000000;
    mismatches++;
    final_report();
  end
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One single-word AHB-Lite transfer
  task automatic bus(input logic wr, input logic [31:0] a, wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Reset with the mode pins set to m
  task automatic do_reset(input logic [2:0] m);
    @(posedge hclk);
    hresetn <= 1'b0;
    md <= m;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(negedge hclk);
  endtask
  function automatic logic pul(input int s);
    case (s)
      0: pul = (core_en === 1'b1);
      1: pul = (per_en === 1'b1);
      2: pul = (bus_en === 1'b1);
      3: pul = (mod_en[0] === 1'b1);
      5: pul = (pin_o === 1'b1);
      default: pul = (mod_en[1] === 1'b1);
    endcase
  endfunction
  // Cycles between two pulses of one enable; waits for the first
  task automatic period(input int s, output int p);
    for (int i = 0; i < 3000 && !pul(s); i++) @(negedge hclk);
    @(negedge hclk);
    p = 1;
    while (!pul(s) && p < 3000)
    begin
      @(negedge hclk);
      p++;
    end
  endtask
  // Pulses of one enable within a window
  task automatic cnt(input int s, input int w, output int p);
    p = 0;
    repeat (w)
    begin
      @(negedge hclk);
      if (pul(s)) p++;
    end
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic mode_case(input logic [2:0] m);
    do_reset(m);
    `CHK(mode_reserved, (m inside {3'h0, 3'h1, 3'h2, 3'h7}) ? 1'b0 : 1'b1)
    `CHK(hresp, 1'b0)
    if (m == 3'h7)
    begin
      `CHK(pll2_on, 1'b0)
      `CHK(pin_oe, 1'b0)
      period(2, n);
      `CHK(n >= 7 && n <= 9, 1'b1)
    end
    else if (!mode_reserved)
    begin
      `CHK(pll2_on, 1'b1)
      `CHK(pll2_ratio, (m == 3'h0) ? 3'h1 : 3'h4)
      `CHK(crystal_osc_on, (m == 3'h2) ? 1'b1 : 1'b0)
      `CHK(xdrv, (m == 3'h2) ? 1'b1 : 1'b0)
    end
  endtask
  task automatic freq_case(input logic [2:0] m, c, p, input int eb, ec, ep);
    logic [15:0] v;
    v = 16'h0100;
    {v[15], v[5:4]} = m;
    {v[14], v[3:2]} = c;
    {v[13], v[1:0]} = p;
    bus(1'b1, clk_gen_pkg::WD_COUNT_ADDR, 32'h0000_00fe);
    bus(1'b1, clk_gen_pkg::FREQ_CTRL_ADDR, {16'h0000, v});
    bus(1'b0, clk_gen_pkg::FREQ_CTRL_ADDR, 32'h0);
    `CHK(rd, {16'h0000, v})
    `CHK(pll1_ratio, 3'(eb))
    period(2, n);
    `CHK(n, eb)
    `CHK(core_en, 1'b1)
    period(0, n);
    `CHK(n, ec)
    period(1, n);
    `CHK(n, ep)
    // Bus pin is high for the first half of each bus period
    cnt(5, 12 * eb, n);
    `CHK(n, 12 * ((eb + 1) / 2))
  endtask
  task automatic wd_case(input logic [7:0] c, input logic ep, em, et,
                         input int minc);
    int w;
    bus(1'b1, clk_gen_pkg::WD_COUNT_ADDR, 32'h0000_00fe);
    bus(1'b1, clk_gen_pkg::WD_CTRL_ADDR, {24'h0, c});
    for (w = 0; w < 2000 && !(por_req || man_req || irq); w++)
      @(negedge hclk);
    `CHK(w >= minc && w < 2000, 1'b1)
    `CHK(por_req, ep)
    `CHK(man_req, em)
    `CHK(irq, et)
    bus(1'b0, clk_gen_pkg::WD_CTRL_ADDR, 32'h0);
    `CHK(rd[3], 1'b1)
    bus(1'b1, clk_gen_pkg::WD_CTRL_ADDR, 32'h0);
    @(negedge hclk);
    `CHK(irq, 1'b0)
  endtask
  task automatic power_case();
    bus(1'b1, clk_gen_pkg::STBY_CTRL_ADDR, 32'h0000_0100);
    cnt(3, 40, n);
    `CHK(n, 0)
    cnt(4, 40, n);
    `CHK(n > 0, 1'b1)
    @(posedge hclk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge hclk);
    cnt(0, 40, n);
    `CHK(n, 0)
    cnt(1, 40, n);
    `CHK(n > 0, 1'b1)
    @(posedge hclk);
    sleep_req <= 1'b0;
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    period(0, n);
    `CHK(n < 3000, 1'b1)
    bus(1'b1, clk_gen_pkg::STBY_CTRL_ADDR, 32'h0000_0001);
    bus(1'b1, clk_gen_pkg::WD_COUNT_ADDR, 32'h0000_00f8);
    @(posedge hclk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge hclk);
    cnt(1, 40, n);
    `CHK(n, 0)
    @(posedge hclk);
    sleep_req <= 1'b0;
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    cnt(0, 8, n);
    `CHK(n, 0)
    period(0, n);
    `CHK(n < 3000, 1'b1)
    // Clock enable low freezes the peripheral pulse where it stands
    @(posedge hclk);
    clk_en <= 1'b0;
    cnt(1, 20, n);
    `CHK(n == 0 || n == 20, 1'b1)
    @(posedge hclk);
    clk_en <= 1'b1;
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    htrans = 2'h0;
    hwdata = 32'h0;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    md = 3'h0;
    rd = 32'h0;
    mode_case(3'h0);
    mode_case(3'h1);
    mode_case(3'h2);
    mode_case(3'h7);
    mode_case(3'h3);
    do_reset(3'h0);
    bus(1'b0, clk_gen_pkg::FREQ_CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h0000_0102)
    bus(1'b0, 32'hffff_ff90, 32'h0);
    `CHK(rd, 32'h0)
    freq_case(3'h4, 3'h0, 3'h5, 3, 1, 6);
    freq_case(3'h5, 3'h4, 3'h0, 6, 3, 6);
    freq_case(3'h2, 3'h5, 3'h1, 4, 4, 4);
    freq_case(3'h1, 3'h1, 3'h2, 2, 2, 4);
    freq_case(3'h0, 3'h0, 3'h2, 1, 1, 4);
    wd_case(8'hc0, 1'b1, 1'b0, 1'b0, 0);
    wd_case(8'he0, 1'b0, 1'b1, 1'b0, 0);
    wd_case(8'h80, 1'b0, 1'b0, 1'b1, 0);
    wd_case(8'h83, 1'b0, 1'b0, 1'b1, 100);
    power_case();
    final_report();
  end
endmodule // testbench
